// File: hw/cc_alarm_map.svh
// Purpose: constants of the coulomb counter alarm block
// Assumes: 100 MHz clock, 3-bit register index on the plain port
// Notes: times in ns, cycle counts derived from them
`ifndef CC_ALARM_MAP_SVH
`define CC_ALARM_MAP_SVH

// register indices
`define CC_ADDR_CFG 3'h0
`define CC_ADDR_THR 3'h1
`define CC_ADDR_ACC 3'h2
`define CC_ADDR_STAT 3'h3
`define CC_ADDR_CTRL 3'h4

// field positions
`define CC_CFG_PRESC_LSB 0
`define CC_CFG_VSEL_LSB 4
`define CC_CFG_VOVR_BIT 7
`define CC_STAT_PHASE_BIT 0
`define CC_STAT_CNT_BIT 1
`define CC_STAT_THR_BIT 2
`define CC_CTRL_CLR_BIT 0
`define CC_CTRL_CHECK_BIT 1

// reset values and the all-ones mask
`define CC_RST_BYTE 8'h00
`define CC_RST_RIPPLE 42'h000_0000_0000
`define CC_RST_PHCNT 11'h000
`define CC_RST_BLANK 7'h00
`define CC_ALL_ONES 42'h3FF_FFFF_FFFF

// timing
`define CC_CLK_NS 10
`define CC_FS_NS 11740
`define CC_FS_CYC (`CC_FS_NS / `CC_CLK_NS)
`define CC_BLANK_NS 1000
`define CC_BLANK_CYC (`CC_BLANK_NS / `CC_CLK_NS)

// charge scaling: amount = cycles * 222 / 1024, full scale near 255
`define CC_SCALE_MUL 18'h000DE
`define CC_SCALE_SHIFT 10
`define CC_ACC_BASE 6'h22

`endif

// File: hw/cc_alarm_pkg.sv
// Purpose: types shared by the coulomb counter alarm block
// Assumes: constants come from cc_alarm_map.svh
// Notes: none
package cc_alarm_pkg;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } bus_req_s;

  typedef struct packed {
    logic thr;
    logic cnt_ovf;
    logic phase_ovf;
  } alarm_s;

endpackage

// File: hw/coulomb_counter_alarm_logic.sv
// Purpose: charge accumulation, alarm flags and interrupt of a coulomb counter
// Assumes: sys_rst_i is the battery power-on reset; pins are asynchronous
// Notes: register port is a plain strobe port with read data one cycle later
// How it works
// - charge-phase timeout sets phase overflow flag and pulls interrupt low.
// - after clearing phase overflow, interrupt stays high until a new measured pulse.
// - ripple counter overflow sets counter overflow flag and pulls interrupt low.
// - after clearing counter overflow, release 1us then reassert unless fixed.
// - readable top 8 bits at or above threshold set threshold flag.
// - threshold compared only after each measured charge pulse or a counter write.
// - clear without threshold or counter change keeps interrupt high until next pulse.
// - power-on reset clears every register, adder and ripple counter.
// - charge keeps accumulating during output start-up.
// - enable low stops conversion but keeps counter contents for resume.
// - only battery loss resets the digital registers.
// - interface supply low blocks all register reads and writes.
// - charge phase measured against 11.74us full scale; reaching it means overflow.
// - each enabled charge phase within full scale adds an amount proportional to its measured time.
// - host writes one to clear bit; device releases interrupt and self-clears it.
// - alarm during clear gives 1us high interrupt, then reassert, clear bit zero.
// - 50-bit chain: 8-bit adder carry clocks 42-bit ripple; top 8 readable.
// - four-bit prescaler 0 to 15, reset 0, shortens readable counter span.
`timescale 1ns/1ns
`include "cc_alarm_map.svh"

module coulomb_counter_alarm_logic
  import cc_alarm_pkg::*;
(
  // clock and battery power-on reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // pins from the converter and supplies
  input wire logic charge_phase_i,
  input wire logic conv_enable_i,
  input wire logic interface_supply_ok_i,
  // register port
  input wire bus_req_s bus_i,
  output logic [7:0] rd_data_o,
  // outputs
  output logic irq_n_o,
  output logic conv_run_o,
  output logic [2:0] vout_sel_o,
  output logic vout_override_o
);

  // synchronisers: first stage is read only by the second
  logic ph_s1_q, ph_s2_q, ph_s3_q;
  logic en_s1_q, en_s2_q;
  logic if_s1_q, if_s2_q;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ph_s1_q <= 1'b0;
      ph_s2_q <= 1'b0;
      ph_s3_q <= 1'b0;
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      if_s1_q <= 1'b0;
      if_s2_q <= 1'b0;
    end else begin
      ph_s1_q <= charge_phase_i;
      ph_s2_q <= ph_s1_q;
      ph_s3_q <= ph_s2_q;
      en_s1_q <= conv_enable_i;
      en_s2_q <= en_s1_q;
      if_s1_q <= interface_supply_ok_i;
      if_s2_q <= if_s1_q;
    end
  end

  // register writes, gated by the interface supply
  logic wr_cfg, wr_thr, wr_acc, wr_ctrl, rd_ok;
  assign wr_cfg = bus_i.we && if_s2_q && (bus_i.addr == `CC_ADDR_CFG);
  assign wr_thr = bus_i.we && if_s2_q && (bus_i.addr == `CC_ADDR_THR);
  assign wr_acc = bus_i.we && if_s2_q && (bus_i.addr == `CC_ADDR_ACC);
  assign wr_ctrl = bus_i.we && if_s2_q && (bus_i.addr == `CC_ADDR_CTRL);
  assign rd_ok = bus_i.re && if_s2_q;

  logic [7:0] cfg_q, thr_q;
  logic check_q;
  logic [3:0] presc;
  assign presc = cfg_q[`CC_CFG_PRESC_LSB +: 4];

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cfg_q <= `CC_RST_BYTE;
      thr_q <= `CC_RST_BYTE;
      check_q <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= bus_i.wdata;
      end
      if (wr_thr) begin
        thr_q <= bus_i.wdata;
      end
      if (wr_ctrl) begin
        check_q <= bus_i.wdata[`CC_CTRL_CHECK_BIT];
      end
    end
  end

  // charge-phase duration measurement
  logic [10:0] ph_cnt_q;
  logic ph_to_q;
  logic to_evt, ph_fall, add_evt;
  assign to_evt = ph_s2_q && en_s2_q && !ph_to_q &&
                  (ph_cnt_q == 11'(`CC_FS_CYC - 1));
  assign ph_fall = ph_s3_q && !ph_s2_q;
  // a timed-out pulse cannot be measured, so it adds nothing
  assign add_evt = ph_fall && en_s2_q && !ph_to_q;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ph_cnt_q <= `CC_RST_PHCNT;
    end else if (!ph_s2_q) begin
      ph_cnt_q <= `CC_RST_PHCNT;
    end else if (!ph_to_q && !to_evt) begin
      ph_cnt_q <= ph_cnt_q + 11'h001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ph_to_q <= 1'b0;
    end else if (to_evt) begin
      ph_to_q <= 1'b1;
    end else if (!ph_s2_q) begin
      ph_to_q <= 1'b0;
    end
  end

  // charge amount and adder; counting does not wait for power good
  logic [17:0] prod, prod_sh;
  logic [7:0] amount;
  logic [8:0] sum;
  logic [7:0] adder_q;
  assign prod = 18'(ph_cnt_q) * `CC_SCALE_MUL;
  assign prod_sh = prod >> `CC_SCALE_SHIFT;
  assign amount = prod_sh[7:0];
  assign sum = {1'b0, adder_q} + {1'b0, amount};

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      adder_q <= `CC_RST_BYTE;
    end else if (add_evt) begin
      adder_q <= sum[7:0];
    end
  end

  // ripple counter, prescaler picks the readable window
  logic [41:0] ripple_q, low_mask;
  logic [5:0] acc_base;
  logic [7:0] acc_top;
  logic carry, ovf_evt;
  assign carry = add_evt && sum[8];
  assign acc_base = `CC_ACC_BASE - {2'b00, presc};
  assign acc_top = ripple_q[acc_base +: 8];
  assign low_mask = `CC_ALL_ONES >> presc;
  assign ovf_evt = carry && ((ripple_q & low_mask) == low_mask);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ripple_q <= `CC_RST_RIPPLE;
    end else if (wr_acc) begin
      ripple_q[acc_base +: 8] <= bus_i.wdata;
    end else if (carry) begin
      ripple_q <= ripple_q + 42'h000_0000_0001;
    end
  end

  // threshold compare one cycle after an update, so it sees the new count
  logic cmp_q, cmp_evt;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cmp_q <= 1'b0;
    end else begin
      cmp_q <= add_evt || wr_acc;
    end
  end
  assign cmp_evt = cmp_q && (acc_top >= thr_q);

  // counter overflow stays pending until the count is lowered and prescaler changed
  logic ovf_pend_q, c_low_q, m_chg_q;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ovf_pend_q <= 1'b0;
      c_low_q <= 1'b0;
      m_chg_q <= 1'b0;
    end else if (ovf_evt) begin
      ovf_pend_q <= 1'b1;
      c_low_q <= 1'b0;
      m_chg_q <= 1'b0;
    end else if (ovf_pend_q && c_low_q && m_chg_q) begin
      ovf_pend_q <= 1'b0;
    end else begin
      if (wr_acc && (bus_i.wdata < acc_top)) begin
        c_low_q <= 1'b1;
      end
      if (wr_cfg && (bus_i.wdata[`CC_CFG_PRESC_LSB +: 4] != presc)) begin
        m_chg_q <= 1'b1;
      end
    end
  end

  // clear bit: acts once, then drops by itself
  logic clr_q;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      clr_q <= 1'b0;
    end else if (clr_q) begin
      clr_q <= 1'b0;
    end else if (wr_ctrl) begin
      clr_q <= bus_i.wdata[`CC_CTRL_CLR_BIT];
    end
  end

  // interrupt release window after a clear
  logic [6:0] blank_q;
  logic blank_end;
  assign blank_end = (blank_q == 7'h01);
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      blank_q <= `CC_RST_BLANK;
    end else if (clr_q) begin
      blank_q <= 7'(`CC_BLANK_CYC);
    end else if (blank_q != `CC_RST_BLANK) begin
      blank_q <= blank_q - 7'h01;
    end
  end

  // alarm flags; a set in the clearing cycle wins
  alarm_s flags_q, set_v, clr_v;
  always_comb begin
    set_v.phase_ovf = to_evt;
    set_v.cnt_ovf = ovf_evt || (blank_end && ovf_pend_q);
    set_v.thr = cmp_evt;
    clr_v = clr_q ? 3'b111 : 3'b000;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flags_q <= 3'b000;
    end else begin
      flags_q <= (flags_q & ~clr_v) | set_v;
    end
  end

  // interrupt pin; check mode shows the ripple clock instead
  logic irq_n_q;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_n_q <= 1'b1;
    end else if (check_q) begin
      irq_n_q <= !carry;
    end else if (clr_q || (blank_q != `CC_RST_BLANK)) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !(|flags_q);
    end
  end
  assign irq_n_o = irq_n_q;

  // read data stand one cycle after the strobe, zero otherwise
  logic [7:0] rd_q;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rd_q <= `CC_RST_BYTE;
    end else if (rd_ok && (bus_i.addr == `CC_ADDR_ACC)) begin
      rd_q <= acc_top;
    end else if (rd_ok && (bus_i.addr == `CC_ADDR_STAT)) begin
      rd_q <= {5'h00, flags_q};
    end else begin
      rd_q <= `CC_RST_BYTE;
    end
  end
  assign rd_data_o = rd_q;

  assign conv_run_o = en_s2_q;
  assign vout_sel_o = cfg_q[`CC_CFG_VSEL_LSB +: 3];
  assign vout_override_o = cfg_q[`CC_CFG_VOVR_BIT];

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  property p_phase_ovf;
    to_evt |=> flags_q.phase_ovf ##1 (!irq_n_o || check_q || blank_q != 7'h00);
  endproperty
  a_phase_ovf: assert property (p_phase_ovf) else $error("phase overflow not flagged");

  property p_clr_release;
    (clr_q && !check_q) |-> ##2 irq_n_o [*8];
  endproperty
  a_clr_release: assert property (p_clr_release) else $error("irq not released");

  property p_cnt_ovf;
    ovf_evt |=> flags_q.cnt_ovf;
  endproperty
  a_cnt_ovf: assert property (p_cnt_ovf) else $error("counter overflow lost");

  property p_ovf_reassert;
    (clr_q && ovf_pend_q && !c_low_q && !m_chg_q && !wr_acc && !wr_cfg)
      |-> ##[99:103] flags_q.cnt_ovf;
  endproperty
  a_ovf_reassert: assert property (p_ovf_reassert) else $error("no reassert");

  property p_thr_set;
    (cmp_q && acc_top >= thr_q) |=> flags_q.thr;
  endproperty
  a_thr_set: assert property (p_thr_set) else $error("threshold flag missing");

  property p_thr_cause;
    $rose(flags_q.thr) |-> $past(cmp_q) && $past(acc_top >= thr_q);
  endproperty
  a_thr_cause: assert property (p_thr_cause) else $error("threshold without compare");

  property p_clr_self;
    clr_q |=> !clr_q;
  endproperty
  a_clr_self: assert property (p_clr_self) else $error("clear bit stuck");

  property p_irq_low;
    (flags_q != 3'b000 && blank_q == 7'h00 && !clr_q && !check_q) |=> !irq_n_o;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq not asserted");

  property p_if_block;
    (bus_i.re && !if_s2_q) |=> rd_data_o == 8'h00;
  endproperty
  a_if_block: assert property (p_if_block) else $error("read while supply low");

  property p_hold;
    (!en_s2_q && !wr_acc) |=> $stable(ripple_q) && $stable(adder_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved while disabled");

  property p_fs_limit;
    to_evt |-> ph_cnt_q == 11'h495;
  endproperty
  a_fs_limit: assert property (p_fs_limit) else $error("full scale count wrong");

  c_thr: cover property (cmp_evt ##[1:4] !irq_n_o);
  c_clear: cover property (clr_q ##[1:120] flags_q == 3'b000);
  c_reassert: cover property (blank_end && ovf_pend_q);

endmodule // coulomb_counter_alarm_logic

// File: verif/host_model.sv
// Purpose: host side model that drives the register port of the alarm block
// Assumes: requests change right after a rising edge and last one cycle
// Notes: keeps the queue of expected read data for the bench monitor
`timescale 1ns/1ns
`include "cc_alarm_map.svh"

module host_model
  import cc_alarm_pkg::*;
(
  // clock
  input wire logic clock_i,
  // request to the block
  output bus_req_s bus_o
);
  logic [7:0] exp_q[$];

  initial bus_o = '0;

  // idle fields carry inverted junk so a stale value is never taken for valid
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus_o <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clock_i);
    bus_o <= '{addr: ~a, wdata: ~d, we: 1'b0, re: 1'b0};
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock_i);
    exp_q.push_back(e);
    bus_o <= '{addr: a, wdata: 8'h5A, we: 1'b0, re: 1'b1};
    @(posedge clock_i);
    bus_o <= '{addr: ~a, wdata: 8'hA5, we: 1'b0, re: 1'b0};
  endtask

  // threshold goes up first so the alarm cannot trip again right away
  task automatic clear_alarm(input logic [7:0] thr);
    wr(`CC_ADDR_THR, thr);
    wr(`CC_ADDR_CTRL, 8'h01);
  endtask
endmodule // host_model

// File: verif/testbench.sv
// Purpose: self-checking bench for the coulomb counter alarm block
// Assumes: host_model drives the register port, bench drives the pins
// Notes: read data checked by a monitor against the host's queue
`timescale 1ns/1ns
`include "cc_alarm_map.svh"

module testbench;
  import cc_alarm_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic charge_phase_i = 1'b0;
  logic conv_enable_i = 1'b1;
  logic interface_supply_ok_i = 1'b1;
  bus_req_s bus;
  logic [7:0] rd_data_o;
  logic irq_n_o;
  logic conv_run_o;
  logic [2:0] vout_sel_o;
  logic vout_override_o;
  logic re_seen = 1'b0;
  logic [7:0] t;
  logic [7:0] r;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #5 clock_i = ~clock_i;

  coulomb_counter_alarm_logic i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .charge_phase_i(charge_phase_i), .conv_enable_i(conv_enable_i),
    .interface_supply_ok_i(interface_supply_ok_i), .bus_i(bus), .rd_data_o(rd_data_o),
    .irq_n_o(irq_n_o), .conv_run_o(conv_run_o), .vout_sel_o(vout_sel_o),
    .vout_override_o(vout_override_o));

  host_model i_host (.clock_i(clock_i), .bus_o(bus));

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wait_irq(input logic e);
    int k;
    k = 0;
    while (irq_n_o !== e && k < 20) begin
      @(negedge clock_i);
      k++;
    end
    chk("irq_n_o", {7'h00, e}, {7'h00, irq_n_o});
  endtask

  task automatic hold_irq(input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge clock_i);
      if (irq_n_o !== 1'b1) ok = 1'b0;
    end
    chk("irq_n_o held high", 8'h01, {7'h00, ok});
  endtask

  task automatic pulse(input int n);
    @(posedge clock_i);
    charge_phase_i <= 1'b1;
    repeat (n) @(posedge clock_i);
    charge_phase_i <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clock_i) re_seen <= bus.re;
  always @(negedge clock_i) begin
    if (re_seen) begin
      chk("rd_data_o", i_host.exp_q.pop_front(), rd_data_o);
    end
  end

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("Error timeout expected %h seen %h", 8'h00, 8'h01);
      end_of_test();
    end
  end

  initial begin
    r = 8'($urandom(6670));
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    chk("irq_n_o", 8'h01, {7'h00, irq_n_o});
    chk("cfg pins", 8'h00, {4'h0, vout_override_o, vout_sel_o});
    for (int a = 0; a < 8; a++) begin
      i_host.rd(3'(a), 8'h00);
    end
    $display("test reset done");

    r = 8'($urandom);
    i_host.wr(`CC_ADDR_CFG, r);
    @(negedge clock_i);
    chk("cfg pins", {4'h0, r[7:4]}, {4'h0, vout_override_o, vout_sel_o});
    i_host.rd(`CC_ADDR_CFG, 8'h00);
    $display("test config done");

    t = 8'h10 + 8'($urandom_range(0, 96));
    i_host.wr(`CC_ADDR_THR, t);
    i_host.wr(`CC_ADDR_ACC, t - 8'h01);
    hold_irq(10);
    i_host.wr(`CC_ADDR_ACC, t);
    wait_irq(1'b0);
    i_host.rd(`CC_ADDR_STAT, 8'h04);
    i_host.rd(`CC_ADDR_ACC, t);
    i_host.wr(`CC_ADDR_CTRL, 8'h01);
    wait_irq(1'b1);
    hold_irq(150);
    i_host.rd(`CC_ADDR_STAT, 8'h00);
    pulse(20);
    wait_irq(1'b0);
    i_host.clear_alarm(t + 8'h01);
    wait_irq(1'b1);
    hold_irq(150);
    i_host.rd(`CC_ADDR_STAT, 8'h00);
    $display("test threshold done");

    @(posedge clock_i);
    conv_enable_i <= 1'b0;
    repeat (4) @(negedge clock_i);
    chk("conv_run_o", 8'h00, {7'h00, conv_run_o});
    pulse(1300);
    i_host.rd(`CC_ADDR_STAT, 8'h00);
    @(posedge clock_i);
    conv_enable_i <= 1'b1;
    repeat (4) @(negedge clock_i);
    chk("conv_run_o", 8'h01, {7'h00, conv_run_o});
    i_host.rd(`CC_ADDR_ACC, t);
    $display("test enable done");

    @(posedge clock_i);
    interface_supply_ok_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    i_host.wr(`CC_ADDR_ACC, 8'hFF);
    i_host.rd(`CC_ADDR_ACC, 8'h00);
    hold_irq(10);
    @(posedge clock_i);
    interface_supply_ok_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    i_host.rd(`CC_ADDR_ACC, t);
    $display("test supply done");

    pulse(1100);
    i_host.rd(`CC_ADDR_STAT, 8'h00);
    hold_irq(5);
    pulse(1180);
    wait_irq(1'b0);
    i_host.rd(`CC_ADDR_STAT, 8'h01);
    i_host.wr(`CC_ADDR_CTRL, 8'h01);
    wait_irq(1'b1);
    hold_irq(200);
    i_host.rd(`CC_ADDR_STAT, 8'h00);
    $display("test phase overflow done");

    // check mode: an 80-cycle pulse makes the adder carry once, seen as one low cycle
    i_host.wr(`CC_ADDR_CTRL, 8'h02);
    fork
      pulse(80);
      begin
        repeat (74) @(posedge clock_i);
        wait_irq(1'b0);
      end
    join
    wait_irq(1'b1);
    i_host.wr(`CC_ADDR_CTRL, 8'h00);
    i_host.rd(`CC_ADDR_STAT, 8'h00);
    i_host.rd(`CC_ADDR_ACC, t);
    $display("test counter check done");
    end_of_test();
  end
endmodule // testbench
